// *** design/edm_defs.svh ***
// Purpose: constants of the energy detect measurement block
// Assumes: 250 MHz pclk
// Notes: all counts derived from times in microseconds
// What this block does
// - Energy averages strength over eight symbols, 128us.
// - High rate automatic measurement lasts 32us.
// - High rate manual measurement still 128us listening.
// - Any write to result register requests measurement.
// - Header detect starts automatic measurement, no interrupt.
// - Host requests manual only in receive states; edm_host forwards a start request in any state.
// - Manual end stores result, raises done event.
// - Request outside receive: done event, no measurement.
// - Basic mode value valid 108us after frame start.
// - Extended mode host reads within 224us.
// - No update after automatic result within frame.
// - Result range 0x00 to 0x53 only.
// - Result resets to all ones until the first measurement ends.
// - Zero means floor; n means floor plus n.
// - Host may disable header detect before manual.
// - Host avoids manual requests in extended mode.
// - Extended mode host uses frame end timing.
`ifndef EDM_DEFS_SVH
`define EDM_DEFS_SVH
`define EDM_CLK_MHZ 250
`define EDM_MEAS_US 128
`define EDM_MEAS_HDR_US 32
`define EDM_PROC_US 12
`define EDM_AUTO_VALID_US 108
`define EDM_READ_LIMIT_US 224
`define EDM_HDR_SYNC_US 96
`define EDM_MEAS_CYC (`EDM_MEAS_US * `EDM_CLK_MHZ)
`define EDM_MEAS_HDR_CYC (`EDM_MEAS_HDR_US * `EDM_CLK_MHZ)
`define EDM_PROC_CYC (`EDM_PROC_US * `EDM_CLK_MHZ)
`define EDM_SYMBOLS 8
`define EDM_CNT_W 16
`define EDM_ADDR_W 6
`define EDM_RESULT_OFS 6'h07
`define EDM_RESULT_RESET 8'hff
`define EDM_LEVEL_MAX 8'h53
`define EDM_STRENGTH_MAX 8'h53
// Own APB registers of the host controller
`define EDM_APB_CTRL 12'h000
`define EDM_APB_STATUS 12'h004
`define EDM_APB_RESULT 12'h008
`define EDM_CTRL_START_BIT 0
`define EDM_CTRL_READ_BIT 1
`define EDM_STAT_BUSY_BIT 0
`define EDM_STAT_DONE_BIT 1
`endif

// *** design/edm_pkg.sv ***
// Purpose: shared types of the energy detect block
// Assumes: nothing
// Notes: one-hot state codes
`default_nettype none
package edm_pkg;
  typedef enum logic [2:0] {
    EDM_IDLE = 3'h1,
    EDM_MEAS = 3'h2,
    EDM_PROC = 3'h4
  } edm_state_t;
  typedef enum logic [3:0] {
    EDM_H_IDLE = 4'h1,
    EDM_H_REQ = 4'h2,
    EDM_H_WAIT = 4'h4,
    EDM_H_READ = 4'h8
  } edm_host_state_t;
endpackage
`default_nettype wire

// *** design/edm_if.sv ***
// Purpose: register port and events between host and device
// Assumes: single pclk domain
// Notes: one-cycle strobes for reg_wr and reg_rd
`default_nettype none
interface edm_if (
  input wire logic pclk
);
  logic reg_wr;
  logic reg_rd;
  logic [5:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic measure_done_event;
  logic frame_end_event;
  modport device (
    input reg_wr, reg_rd, reg_addr, reg_wdata,
    output reg_rdata, measure_done_event, frame_end_event
  );
  modport host (
    output reg_wr, reg_rd, reg_addr, reg_wdata,
    input reg_rdata, measure_done_event, frame_end_event
  );
endinterface
`default_nettype wire

// *** design/edm_average.sv ***
// Purpose: sums strength samples and scales to an 8-bit level
// Assumes: sample strobe eight times per window
// Notes: result clamped to the valid range
`default_nettype none
`include "edm_defs.svh"
module edm_average
  import edm_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic clear,
  input wire logic sample,
  input wire logic [7:0] strength,
  // Result
  output logic [7:0] level
);
  logic [10:0] acc;
  logic [10:0] next_acc;
  logic [7:0] avg;
  always_comb begin
    next_acc = acc;
    if (clear) begin
      next_acc = 11'h000;
    end else if (sample) begin
      next_acc = acc + {3'h0, strength};
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc <= 11'h000;
    end else begin
      acc <= next_acc;
    end
  end
  always_comb begin
    avg = acc[10:3];
    level = (avg > `EDM_LEVEL_MAX) ? `EDM_LEVEL_MAX : avg;
  end
endmodule
`default_nettype wire

// *** design/edm_device.sv ***
// Purpose: energy detect measurement of the transceiver
// Assumes: strength input in 1 dB steps above the floor
// Notes: result register at the documented offset
`default_nettype none
`include "edm_defs.svh"
module edm_device
  import edm_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Register side
  edm_if.device bus,
  // Receiver side
  input wire logic rx_listen,
  input wire logic rx_busy,
  input wire logic high_rate,
  input wire logic header_detect,
  input wire logic header_detect_off,
  input wire logic frame_end,
  input wire logic [7:0] strength,
  // Status
  output logic measuring
);
  // Control state
  edm_state_t state;
  edm_state_t next_state;
  logic [`EDM_CNT_W-1:0] cnt;
  logic [`EDM_CNT_W-1:0] next_cnt;
  logic [`EDM_CNT_W-1:0] limit;
  logic [`EDM_CNT_W-1:0] next_limit;
  logic is_manual;
  logic next_is_manual;

  // Result, frame lock and done event
  logic frame_locked;
  logic next_frame_locked;
  logic [7:0] energy_level_value;
  logic [7:0] next_energy_level_value;
  logic done_pulse;
  logic next_done_pulse;
  logic [7:0] next_rdata;
  logic [7:0] rdata;

  // Request decode and sampling
  logic manual_req;
  logic auto_req;
  logic clear_acc;
  logic sample;
  logic [7:0] avg_level;
  logic in_rx;
  logic [`EDM_CNT_W-1:0] sym_len;

  // Symbol pacing
  logic [`EDM_CNT_W-1:0] sym_cnt;
  logic [`EDM_CNT_W-1:0] next_sym_cnt;
  logic [2:0] sym_idx;
  logic [2:0] next_sym_idx;
  logic sym_end;

  assign in_rx = rx_listen | rx_busy;
  assign manual_req = bus.reg_wr && bus.reg_addr == `EDM_RESULT_OFS;
  assign auto_req = header_detect && !header_detect_off;
  // Window is eight symbols; a symbol counter avoids a divider
  assign sym_len = limit >> 3;
  assign sym_end = sym_cnt == sym_len - 1'b1;
  assign sample = state == EDM_MEAS && sym_len != '0 && sym_end;

  edm_average u_avg (
    .pclk(pclk),
    .presetn(presetn),
    .clear(clear_acc),
    .sample(sample),
    .strength(strength),
    .level(avg_level)
  );

  // Symbol pacing: one strength sample at the end of each symbol
  always_comb begin
    next_sym_cnt = sym_cnt;
    next_sym_idx = sym_idx;
    if (state != EDM_MEAS) begin
      next_sym_cnt = '0;
      next_sym_idx = 3'h0;
    end else if (sym_end) begin
      // Restart at every symbol boundary
      next_sym_cnt = '0;
      next_sym_idx = sym_idx + 3'h1;
    end else begin
      next_sym_cnt = sym_cnt + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sym_cnt <= '0;
      sym_idx <= 3'h0;
    end else begin
      sym_cnt <= next_sym_cnt;
      sym_idx <= next_sym_idx;
    end
  end

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_limit = limit;
    next_is_manual = is_manual;
    next_frame_locked = frame_locked;
    next_energy_level_value = energy_level_value;
    next_done_pulse = 1'b0;
    clear_acc = 1'b0;
    // Frame lock ends with the frame or the busy receive
    if (frame_end || !rx_busy) begin
      next_frame_locked = 1'b0;
    end
    // Measurement sequencing
    case (state)
      EDM_IDLE: begin
        if (auto_req) begin
          next_state = EDM_MEAS;
          next_is_manual = 1'b0;
          next_cnt = '0;
          next_frame_locked = 1'b0;
          next_limit = high_rate ? `EDM_CNT_W'(`EDM_MEAS_HDR_CYC) : `EDM_CNT_W'(`EDM_MEAS_CYC);
          clear_acc = 1'b1;
        end else if (manual_req) begin
          if (in_rx && !frame_locked) begin
            next_state = EDM_MEAS;
            next_is_manual = 1'b1;
            next_cnt = '0;
            next_limit = `EDM_CNT_W'(`EDM_MEAS_CYC);
            clear_acc = 1'b1;
          end else begin
            next_done_pulse = 1'b1;
          end
        end
      end
      EDM_MEAS: begin
        next_cnt = cnt + 1'b1;
        if (sample && sym_idx == 3'h7) begin
          next_state = EDM_PROC;
          next_cnt = '0;
        end
      end
      EDM_PROC: begin
        next_cnt = cnt + 1'b1;
        if (cnt == `EDM_CNT_W'(`EDM_PROC_CYC - 1)) begin
          next_state = EDM_IDLE;
          next_energy_level_value = avg_level;
          if (is_manual) begin
            next_done_pulse = 1'b1;
          end else begin
            next_frame_locked = rx_busy;
          end
        end
      end
      default: begin
        next_state = EDM_IDLE;
      end
    endcase
    // A manual request during an automatic measurement still gets its done event
    if (state != EDM_IDLE && manual_req && !is_manual) begin
      next_done_pulse = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= EDM_IDLE;
      cnt <= '0;
      limit <= '0;
      is_manual <= 1'b0;
      frame_locked <= 1'b0;
      energy_level_value <= `EDM_RESULT_RESET;
      done_pulse <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      limit <= next_limit;
      is_manual <= next_is_manual;
      frame_locked <= next_frame_locked;
      energy_level_value <= next_energy_level_value;
      done_pulse <= next_done_pulse;
    end
  end

  // Read path: the stored level reaches the port one cycle after it lands
  always_comb begin
    next_rdata = energy_level_value;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata <= `EDM_RESULT_RESET;
    end else begin
      rdata <= next_rdata;
    end
  end

  assign bus.reg_rdata = (bus.reg_addr == `EDM_RESULT_OFS) ? rdata : 8'h00;
  assign bus.measure_done_event = done_pulse;
  assign bus.frame_end_event = frame_end;
  assign measuring = state != EDM_IDLE;
endmodule
`default_nettype wire

// *** design/edm_host.sv ***
// Purpose: host controller driving the device register port from APB
// Assumes: APB slave with zero wait states
// Notes: start by CTRL bit 0, read result by CTRL bit 1
`default_nettype none
`include "edm_defs.svh"
module edm_host
  import edm_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Device side
  edm_if.host dev
);
  edm_host_state_t state;
  edm_host_state_t next_state;
  logic busy_done;
  logic next_busy_done;
  logic [7:0] result;
  logic [7:0] next_result;
  logic [31:0] next_prdata;
  logic wr_go;
  logic mapped;
  logic want_start;
  logic want_read;

  assign wr_go = psel && penable && pwrite;
  assign mapped = paddr == `EDM_APB_CTRL || paddr == `EDM_APB_STATUS || paddr == `EDM_APB_RESULT;
  assign want_start = wr_go && paddr == `EDM_APB_CTRL && pwdata[`EDM_CTRL_START_BIT];
  assign want_read = wr_go && paddr == `EDM_APB_CTRL && pwdata[`EDM_CTRL_READ_BIT];
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  always_comb begin
    next_state = state;
    next_busy_done = busy_done;
    next_result = result;
    dev.reg_wr = 1'b0;
    dev.reg_rd = 1'b0;
    dev.reg_addr = `EDM_RESULT_OFS;
    dev.reg_wdata = 8'h00;
    case (state)
      EDM_H_IDLE: begin
        if (want_start) begin
          next_state = EDM_H_REQ;
          next_busy_done = 1'b0;
        end else if (want_read) begin
          next_state = EDM_H_READ;
        end
      end
      EDM_H_REQ: begin
        dev.reg_wr = 1'b1;
        next_state = EDM_H_WAIT;
      end
      EDM_H_WAIT: begin
        if (dev.measure_done_event) begin
          next_state = EDM_H_READ;
        end
      end
      EDM_H_READ: begin
        dev.reg_rd = 1'b1;
        next_result = dev.reg_rdata;
        next_busy_done = 1'b1;
        next_state = EDM_H_IDLE;
      end
      default: begin
        next_state = EDM_H_IDLE;
      end
    endcase
    next_prdata = 32'h0000_0000;
    if (psel && !penable && !pwrite) begin
      if (paddr == `EDM_APB_STATUS) begin
        next_prdata[`EDM_STAT_BUSY_BIT] = state != EDM_H_IDLE;
        next_prdata[`EDM_STAT_DONE_BIT] = busy_done;
      end else if (paddr == `EDM_APB_RESULT) begin
        next_prdata[7:0] = result;
      end
    end else begin
      next_prdata = prdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= EDM_H_IDLE;
      busy_done <= 1'b0;
      result <= `EDM_RESULT_RESET;
      prdata <= 32'h0000_0000;
    end else begin
      state <= next_state;
      busy_done <= next_busy_done;
      result <= next_result;
      prdata <= next_prdata;
    end
  end
endmodule
`default_nettype wire

// *** verif/edm_check_sva.sv ***
// Purpose: interface checks between host and device
// Assumes: single pclk domain
// Notes: measurement counts at full length
`default_nettype none
`include "edm_defs.svh"
module edm_check (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [5:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // Events
  input wire logic measure_done_event,
  input wire logic frame_end_event
);
  localparam int MAN_LO = `EDM_MEAS_CYC + `EDM_PROC_CYC;
  localparam int MAN_HI = MAN_LO + 2;
  logic pending;
  logic next_pending;
  logic started;
  logic next_started;
  logic [16:0] cnt;
  logic [16:0] next_cnt;
  logic wr7;
  logic rd7;
  assign wr7 = reg_wr && (reg_addr == 6'h07);
  assign rd7 = reg_rd && (reg_addr == 6'h07);
  // Cycles from the last request to its done event
  always_comb begin
    next_started = started | wr7;
    next_pending = wr7 | (pending & ~measure_done_event);
    next_cnt = wr7 ? 17'h00000 : (pending ? cnt + 17'h00001 : cnt);
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pending <= 1'b0;
      started <= 1'b0;
      cnt <= 17'h00000;
    end else begin
      pending <= next_pending;
      started <= next_started;
      cnt <= next_cnt;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  done_pulse_a: assert property (measure_done_event |=> !measure_done_event)
    else $error("done event longer than one cycle");
  done_cause_a: assert property (measure_done_event |-> pending)
    else $error("done event without a request");
  done_time_a: assert property (measure_done_event |-> int'(cnt) < 4 || int'(cnt) >= MAN_LO)
    else $error("done event at a wrong time");
  done_bound_a: assert property (pending |-> int'(cnt) <= MAN_HI)
    else $error("done event missing");
  reset_value_a: assert property (rd7 && !started |-> reg_rdata == 8'hff)
    else $error("result not at reset value");
  level_range_a: assert property (rd7 && reg_rdata != 8'hff |-> reg_rdata <= 8'h53)
    else $error("result out of range");
endmodule
`default_nettype wire

// *** verif/test_energy_detect_measurement.sv ***
// Purpose: drives the host over APB and the receiver side
// Assumes: host and device joined by the interface
// Notes: full-length counts
`default_nettype none
`include "edm_defs.svh"
module test_energy_detect_measurement
  import edm_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic rx_listen = 1'b0;
  logic rx_busy = 1'b0;
  logic high_rate = 1'b0;
  logic header_detect = 1'b0;
  logic header_detect_off = 1'b0;
  logic frame_end = 1'b0;
  logic [7:0] strength = 8'h00;
  logic measuring;
  int miscompares = 0;
  int check_count = 0;
  int done_cnt = 0;
  always #2 pclk = ~pclk;
  edm_if bus_if (.pclk(pclk));
  edm_device edm_device_inst (.pclk(pclk), .presetn(presetn), .bus(bus_if), .rx_listen(rx_listen),
    .rx_busy(rx_busy), .high_rate(high_rate), .header_detect(header_detect),
    .header_detect_off(header_detect_off), .frame_end(frame_end), .strength(strength), .measuring(measuring));
  edm_host edm_host_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .dev(bus_if));
  edm_check edm_check_inst (.pclk(pclk), .presetn(presetn), .reg_wr(bus_if.reg_wr), .reg_rd(bus_if.reg_rd),
    .reg_addr(bus_if.reg_addr), .reg_wdata(bus_if.reg_wdata), .reg_rdata(bus_if.reg_rdata),
    .measure_done_event(bus_if.measure_done_event), .frame_end_event(bus_if.frame_end_event));
  always @(posedge pclk) begin
    if (bus_if.measure_done_event === 1'b1) done_cnt <= done_cnt + 1;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
    output logic e);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic get_result(input logic [31:0] exp);
    logic [31:0] q;
    logic e;
    int n;
    apb(1'b1, `EDM_APB_CTRL, 32'h2, q, e);
    n = 0;
    do begin
      apb(1'b0, `EDM_APB_STATUS, 32'h0, q, e);
      n++;
    end while (q[0] !== 1'b0 && n < 20);
    chk(q, 32'h2);
    apb(1'b0, `EDM_APB_RESULT, 32'h0, q, e);
    chk(q, exp);
  endtask
  // Request and wait for exactly one done event
  task automatic start_wait(input int lim);
    logic [31:0] q;
    logic e;
    int n;
    int s;
    s = done_cnt;
    n = 0;
    apb(1'b1, `EDM_APB_CTRL, 32'h1, q, e);
    while (done_cnt == s && n < lim) begin
      @(posedge pclk);
      n++;
    end
    chk(32'(done_cnt - s), 32'h1);
  endtask
  task automatic stop_test();
    if (miscompares == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge pclk);
    miscompares++;
    stop_test();
  end
  initial begin
    logic [31:0] q;
    logic e;
    int d;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    get_result(32'hff);
    apb(1'b0, 12'h0f0, 32'h0, q, e);
    chk({31'h0, e}, 32'h1);
    start_wait(100);
    chk({31'h0, measuring}, 32'h0);
    get_result(32'hff);
    rx_listen <= 1'b1;
    high_rate <= 1'b1;
    header_detect_off <= 1'b1;
    strength <= 8'h20;
    start_wait(36000);
    get_result(32'h20);
    // Frame start at high rate, strength above the top level
    rx_listen <= 1'b0;
    rx_busy <= 1'b1;
    header_detect_off <= 1'b0;
    strength <= 8'h7f;
    header_detect <= 1'b1;
    @(posedge pclk);
    header_detect <= 1'b0;
    d = done_cnt;
    repeat (10880) @(posedge pclk);
    chk({31'h0, measuring}, 32'h1);
    get_result(32'h20);
    repeat (200) @(posedge pclk);
    get_result(32'h53);
    chk({31'h0, measuring}, 32'h0);
    chk(32'(done_cnt - d), 32'h0);
    strength <= 8'h10;
    start_wait(100);
    get_result(32'h53);
    frame_end <= 1'b1;
    rx_busy <= 1'b0;
    @(posedge pclk);
    frame_end <= 1'b0;
    get_result(32'h53);
    stop_test();
  end
endmodule
`default_nettype wire
